// >>> src/sfp_pkg.sv
// Package: constants and carriers for the serial flash program/power logic
package sfp_pkg;
// ----------------------------------------------------------------
// ----------------------------------------------------------------

// ----------------------------------------------------------------
// opcodes and framing
// ----------------------------------------------------------------
localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
localparam logic [7:0] OP_QUAD_PROGRAM = 8'h38;
localparam logic [7:0] OP_POWER_DOWN = 8'hB9;
localparam logic [7:0] OP_RELEASE = 8'hAB;
localparam logic [7:0] OP_SECURE_ENTER = 8'hB1;
localparam logic [7:0] OP_SECURE_EXIT = 8'hC1;
localparam logic [2:0] NB_OPCODE = 3'h1;
localparam logic [2:0] NB_HEADER = 3'h4;
localparam logic [2:0] NB_DATA = 3'h5;
// signature value is arbitrary
localparam logic [7:0] SIG_DEFAULT = 8'h5A;

// ----------------------------------------------------------------
// array geometry and protection
// ----------------------------------------------------------------
localparam int ARRAY_BYTES = 262144;
localparam int PROT_BASE = 2048;
localparam logic [3:0] PROT_ALL = 4'h7;

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
localparam int CLK_MHZ = 25;
localparam int T_DP_NS = 10000;
localparam int T_RES1_NS = 10000;
localparam int T_RES2_NS = 10000;
localparam int T_PP_NS = 1000000;
localparam int DP_CYC = (T_DP_NS * CLK_MHZ + 999) / 1000;
localparam int RES1_CYC = (T_RES1_NS * CLK_MHZ + 999) / 1000;
localparam int RES2_CYC = (T_RES2_NS * CLK_MHZ + 999) / 1000;
localparam int PP_CYC_DEFAULT = (T_PP_NS * CLK_MHZ + 999) / 1000;

// ----------------------------------------------------------------
// carriers
// ----------------------------------------------------------------
typedef struct packed {
  logic rd;
  logic we;
  logic otp;
  logic [17:0] addr;
  logic [7:0] wdata;
} sfp_mem_req_t;

typedef struct packed {
  logic write_in_progress;
  logic write_enable_latch;
  logic program_fail;
  logic deep_power_down;
  logic otp_mode;
} sfp_status_t;

localparam sfp_mem_req_t MEM_RESET = '0;
localparam sfp_status_t STATUS_RESET = '0;

typedef enum {
  ST_IDLE, ST_PRG_RD, ST_PRG_LAT, ST_PRG_WR, ST_PRG_WAIT, ST_DP_WAIT, ST_RL_WAIT
} sfp_state_t;

endpackage

// >>> src/sfp_core.sv
// Module: serial flash program, power-down, signature and secure-area logic
`timescale 1ns/100ps
module sfp_core #(
  parameter int PP_CYC = sfp_pkg::PP_CYC_DEFAULT,
  parameter logic [7:0] SIG_ID = sfp_pkg::SIG_DEFAULT
) (
  // system
  input wire logic clk,
  input wire logic rstn,
  // serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] quad_io_in,
  output logic [3:0] quad_io_out,
  output logic [3:0] quad_io_oe,
  // configuration
  input wire logic quad_enable_bit,
  input wire logic [3:0] protect_bits,
  input wire logic otp_locked,
  // status
  output sfp_pkg::sfp_status_t status,
  output logic reg_write_block,
  // array
  output sfp_pkg::sfp_mem_req_t mem_req,
  input wire logic [7:0] mem_rdata
);
  import sfp_pkg::*;

  // ----------------------------------------------------------------
  // link side: byte assembly on the serial clock
  // ----------------------------------------------------------------
  logic fresh;
  logic frame_tg;
  logic [7:0] shreg;
  logic [7:0] opcode;
  logic [2:0] part;
  logic [2:0] nbytes;
  logic [23:0] addr;
  logic [7:0] didx;
  logic [7:0] buf_idx;
  logic [7:0] page_buf [256];
  logic [255:0] page_mask;
  logic bs1;
  logic bs2;
  logic quad_now;
  logic [2:0] cur_part;
  logic [2:0] cur_nb;
  logic [2:0] next_part;
  logic [7:0] next_byte;
  logic byte_done;
  logic data_byte;

  always_comb begin
    cur_part = fresh ? 3'h0 : part;
    cur_nb = fresh ? 3'h0 : nbytes;
    quad_now = (opcode == OP_QUAD_PROGRAM) && (cur_nb != 3'h0);
    // quad: high nibble first, line 3 is the nibble msb
    if (quad_now) begin
      next_byte = {shreg[3:0], quad_io_in};
      next_part = cur_part + 3'h4;
    end else begin
      next_byte = {shreg[6:0], quad_io_in[0]};
      next_part = cur_part + 3'h1;
    end
    byte_done = (next_part == 3'h0);
    data_byte = byte_done && (cur_nb >= NB_HEADER);
    buf_idx = addr[7:0] + didx;
  end

  // select high marks the next edge as the first of a frame; reset does too,
  // so the very first frame never sees an unknown marker
  always_ff @(posedge sclk or posedge cs_n or negedge rstn) begin
    if (!rstn) begin
      fresh <= 1'b1;
    end else if (cs_n) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  // sclk is idle during reset, so the release needs no synchroniser here
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      part <= 3'h0;
      nbytes <= 3'h0;
      opcode <= 8'h00;
      frame_tg <= 1'b0;
    end else begin
      part <= next_part;
      if (fresh) begin
        frame_tg <= ~frame_tg;
      end
      if (byte_done && cur_nb != NB_DATA) begin
        nbytes <= cur_nb + 3'h1;
      end else begin
        nbytes <= cur_nb;
      end
      if (byte_done && cur_nb == 3'h0) begin
        opcode <= next_byte;
      end
    end
  end

  always_ff @(posedge sclk) begin
    shreg <= next_byte;
    if (byte_done && cur_nb != 3'h0 && cur_nb < NB_HEADER) begin
      addr <= {addr[15:0], next_byte};
    end
    if (fresh) begin
      didx <= 8'h00;
    end else if (data_byte) begin
      didx <= didx + 8'h01;
    end
    // index wraps mod 256, so later bytes overwrite earlier ones
    if (data_byte) begin
      page_buf[buf_idx] <= next_byte;
    end
  end

  always_ff @(posedge sclk) begin
    if (fresh) begin
      page_mask <= '0;
    end else if (data_byte) begin
      page_mask[buf_idx] <= 1'b1;
    end
  end

  always_ff @(posedge sclk) begin
    bs1 <= status.write_in_progress;
    bs2 <= bs1;
  end

  // ----------------------------------------------------------------
  // link side: signature output on the falling edge
  // ----------------------------------------------------------------
  logic res_out;
  logic so_oe;
  logic so_bit;
  logic [2:0] obit;

  assign res_out = (opcode == OP_RELEASE) && (nbytes >= NB_HEADER) && !bs2 && !fresh;

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      so_oe <= 1'b0;
      so_bit <= 1'b0;
      obit <= 3'h0;
    end else if (res_out) begin
      so_oe <= 1'b1;
      so_bit <= SIG_ID[3'h7 - obit];
      obit <= obit + 3'h1;
    end
  end

  assign quad_io_out = {2'b00, so_bit, 1'b0};
  assign quad_io_oe = {2'b00, so_oe, 1'b0};

  // ----------------------------------------------------------------
  // crossing: select level and frame toggle into the system clock
  // ----------------------------------------------------------------
  logic cs1;
  logic cs2;
  logic cs3;
  logic tg1;
  logic tg2;
  logic tg_seen;
  logic frame_end;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cs1 <= 1'b1;
      cs2 <= 1'b1;
      cs3 <= 1'b1;
      tg1 <= 1'b0;
      tg2 <= 1'b0;
      tg_seen <= 1'b0;
    end else begin
      cs1 <= cs_n;
      cs2 <= cs1;
      cs3 <= cs2;
      tg1 <= frame_tg;
      tg2 <= tg1;
      if (cs2 && !cs3) begin
        tg_seen <= tg2;
      end
    end
  end

  // frame words are stable once select is high and sclk has stopped
  assign frame_end = cs2 && !cs3 && (tg2 != tg_seen);

  // ----------------------------------------------------------------
  // command decode at the end of a frame
  // ----------------------------------------------------------------
  function automatic logic is_protected(input logic [17:0] a, input logic [3:0] bp);
    int span;
    span = PROT_BASE << bp;
    is_protected = (bp != 4'h0) && ((bp >= PROT_ALL) || (int'(a) >= ARRAY_BYTES - span));
  endfunction

  sfp_state_t state;
  logic [23:0] timer;
  logic [7:0] idx;
  logic idle_ok;
  logic one_byte;
  logic prog_cmd;
  logic blocked;
  logic go_prog;
  logic go_fail;
  logic go_write_enable_cmd;
  logic go_dp;
  logic go_rel;
  logic go_enter;
  logic go_exit;
  logic [17:0] prog_addr;

  always_comb begin
    idle_ok = frame_end && (state == ST_IDLE);
    one_byte = (part == 3'h0) && (nbytes == NB_OPCODE);
    prog_cmd = idle_ok && !status.deep_power_down && (part == 3'h0)
      && (nbytes == NB_DATA) && status.write_enable_latch
      && ((opcode == OP_PAGE_PROGRAM)
      || (opcode == OP_QUAD_PROGRAM && quad_enable_bit));
    blocked = status.otp_mode ? otp_locked : is_protected(addr[17:0], protect_bits);
    go_prog = prog_cmd && !blocked;
    go_fail = prog_cmd && blocked;
    go_write_enable_cmd = idle_ok && !status.deep_power_down && one_byte && opcode == OP_WRITE_ENABLE;
    go_dp = idle_ok && !status.deep_power_down && one_byte && opcode == OP_POWER_DOWN;
    // while powered down only the release opcode reaches a state change
    go_rel = idle_ok && status.deep_power_down && opcode == OP_RELEASE
      && (one_byte || (part == 3'h0 && nbytes == NB_DATA));
    go_enter = idle_ok && !status.deep_power_down && one_byte && opcode == OP_SECURE_ENTER;
    go_exit = idle_ok && !status.deep_power_down && one_byte && opcode == OP_SECURE_EXIT;
    if (status.otp_mode) begin
      prog_addr = {9'h000, addr[8], idx};
    end else begin
      prog_addr = {addr[17:8], idx};
    end
  end

  // ----------------------------------------------------------------
  // self-timed sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= ST_IDLE;
      timer <= 24'h000000;
      idx <= 8'h00;
      mem_req <= MEM_RESET;
    end else begin
      mem_req.rd <= 1'b0;
      mem_req.we <= 1'b0;
      case (state)
        ST_IDLE: begin
          idx <= 8'h00;
          if (go_prog) begin
            state <= ST_PRG_RD;
          end else if (go_dp) begin
            state <= ST_DP_WAIT;
            timer <= 24'(DP_CYC);
          end else if (go_rel) begin
            state <= ST_RL_WAIT;
            timer <= one_byte ? 24'(RES1_CYC) : 24'(RES2_CYC);
          end
        end
        ST_PRG_RD: begin
          if (page_mask[idx]) begin
            mem_req.rd <= 1'b1;
            mem_req.otp <= status.otp_mode;
            mem_req.addr <= prog_addr;
            state <= ST_PRG_LAT;
          end else if (idx == 8'hFF) begin
            state <= ST_PRG_WAIT;
            timer <= 24'(PP_CYC);
          end else begin
            idx <= idx + 8'h01;
          end
        end
        ST_PRG_LAT: begin
          state <= ST_PRG_WR;
        end
        ST_PRG_WR: begin
          mem_req.we <= 1'b1;
          mem_req.wdata <= mem_rdata & page_buf[idx];
          idx <= idx + 8'h01;
          if (idx == 8'hFF) begin
            state <= ST_PRG_WAIT;
            timer <= 24'(PP_CYC);
          end else begin
            state <= ST_PRG_RD;
          end
        end
        ST_PRG_WAIT, ST_DP_WAIT, ST_RL_WAIT: begin
          if (timer <= 24'h000001) begin
            state <= ST_IDLE;
          end else begin
            timer <= timer - 24'h000001;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  logic cyc_done;
  assign cyc_done = (timer <= 24'h000001);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      status <= STATUS_RESET;
    end else begin
      if (go_prog) begin
        status.write_in_progress <= 1'b1;
      end else if (state == ST_PRG_WAIT && cyc_done) begin
        status.write_in_progress <= 1'b0;
      end
      if (go_write_enable_cmd) begin
        status.write_enable_latch <= 1'b1;
      end else if (go_fail || (state == ST_PRG_WAIT && cyc_done)) begin
        status.write_enable_latch <= 1'b0;
      end
      if (go_fail) begin
        status.program_fail <= 1'b1;
      end else if (state == ST_PRG_WAIT && cyc_done) begin
        status.program_fail <= 1'b0;
      end
      if (state == ST_DP_WAIT && cyc_done) begin
        status.deep_power_down <= 1'b1;
      end else if (state == ST_RL_WAIT && cyc_done) begin
        status.deep_power_down <= 1'b0;
      end
      if (go_enter) begin
        status.otp_mode <= 1'b1;
      end else if (go_exit) begin
        status.otp_mode <= 1'b0;
      end
    end
  end

  assign reg_write_block = status.otp_mode;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence prog_launch_s;
    go_prog ##1 status.write_in_progress;
  endsequence

  sequence prog_finish_s;
    state == ST_PRG_WAIT && cyc_done ##1 !status.write_in_progress;
  endsequence

  latch_needed_a: assert property ($rose(status.write_in_progress) |-> $past(status.write_enable_latch))
    else $error("program began without write enable latch");
  prog_start_a: assert property (go_prog |-> prog_launch_s ##1 state != ST_IDLE)
    else $error("program start did not raise busy");
  prog_end_a: assert property (prog_finish_s |-> !status.write_enable_latch && !status.program_fail)
    else $error("program end left latch or fail flag set");
  mid_byte_a: assert property (idle_ok && part != 3'h0 |=> state == ST_IDLE && $stable(status))
    else $error("partial byte frame changed state");
  prot_fail_a: assert property (go_fail |=> status.program_fail && !status.write_in_progress ##1 state == ST_IDLE)
    else $error("protected program not refused");
  quad_gate_a: assert property (idle_ok && opcode == OP_QUAD_PROGRAM && !quad_enable_bit
    |=> !status.write_in_progress)
    else $error("quad program ran without quad enable");
  clear_only_a: assert property (mem_req.we |-> (mem_req.wdata & ~$past(mem_rdata)) == 8'h00)
    else $error("program set a bit to one");
  dp_entry_a: assert property (go_dp |=> state == ST_DP_WAIT && !status.deep_power_down)
    else $error("power-down entered without delay");
  dp_ignore_a: assert property (status.deep_power_down && idle_ok && opcode != OP_RELEASE
    |=> $stable(status))
    else $error("command acted while powered down");
  // a running program cycle keeps counting down whatever frames arrive
  busy_release_a: assert property (state == ST_PRG_WAIT && !cyc_done
    |=> state == ST_PRG_WAIT && timer == $past(timer) - 24'h000001)
    else $error("release interrupted a running cycle");

endmodule

// >>> testbench/sfp_host.sv
// Host-side model that frames commands on the serial link
`timescale 1ns/100ps
module sfp_host (
  // serial link
  output logic sclk,
  output logic cs_n,
  output logic [3:0] quad_io_in,
  input wire logic [3:0] quad_io_out,
  input wire logic [3:0] quad_io_oe
);
  logic [15:0] rx;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    quad_io_in = 4'h0;
    rx = 16'h0000;
  end

  // ----------------------------------------------------------------
  // one link period; lines change while the clock is low
  // ----------------------------------------------------------------
  task automatic bit_out(input logic [3:0] v);
    quad_io_in = v;
    #40 sclk = 1'b1;
    // an output line that nobody drives reads as its pull-up
    rx = {rx[14:0], quad_io_oe[1] ? quad_io_out[1] : 1'b1};
    #40 sclk = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // quad_from: first byte sent as nibbles; extra: stray bits at the end
  // ----------------------------------------------------------------
  task automatic frame(input logic [7:0] b[$], input int quad_from, input int extra);
    #13 cs_n = 1'b0;
    foreach (b[i]) begin
      if (i >= quad_from) begin
        bit_out(b[i][7:4]);
        bit_out(b[i][3:0]);
      end else begin
        // upper lines carry the inverse so a design that listens to them is caught
        for (int k = 7; k >= 0; k--) bit_out({{3{~b[i][k]}}, b[i][k]});
      end
    end
    for (int k = 0; k < extra; k++) bit_out(4'h5);
    #20 cs_n = 1'b1;
    // released lines must not keep the last value
    quad_io_in = ~quad_io_in;
  endtask
endmodule

// >>> testbench/sfp_core_tb_top.sv
// Self-checking bench for the serial flash program and power-down logic
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
module sfp_core_tb_top;
  import sfp_pkg::*;
  localparam int PPC = 20;
  logic clk = 1'b0;
  logic rstn, sclk, cs_n, qen, lock, rwb;
  logic [3:0] qin, qout, qoe, prot;
  logic [7:0] rdata;
  sfp_status_t status;
  sfp_mem_req_t mreq;
  logic [7:0] mem [logic [18:0]];
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;

  sfp_core #(.PP_CYC(PPC)) dut (.clk(clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n),
    .quad_io_in(qin), .quad_io_out(qout), .quad_io_oe(qoe), .quad_enable_bit(qen),
    .protect_bits(prot), .otp_locked(lock), .status(status), .reg_write_block(rwb),
    .mem_req(mreq), .mem_rdata(rdata));
  sfp_host host (.sclk(sclk), .cs_n(cs_n), .quad_io_in(qin), .quad_io_out(qout),
    .quad_io_oe(qoe));

  always #20 clk = ~clk;

  // ----------------------------------------------------------------
  // array stand-in: erased reads FF, data registered by the edge that takes the read;
  // otherwise the bus toggles so that a late sample is caught
  // ----------------------------------------------------------------
  initial begin
    rdata = 8'h00;
  end
  always @(posedge clk) begin
    rdata <= mreq.rd ? peek({mreq.otp, mreq.addr}) : ~rdata;
    if (mreq.we) mem[{mreq.otp, mreq.addr}] = mreq.wdata;
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      test_done();
    end
  end

  function automatic logic [7:0] peek(input logic [18:0] k);
    return mem.exists(k) ? mem[k] : 8'hFF;
  endfunction

  // ----------------------------------------------------------------
  // shared steps
  // ----------------------------------------------------------------
  task automatic tx(input logic [7:0] b[$], input int qf = 999, input int extra = 0);
    @(posedge clk);
    #1 host.frame(b, qf, extra);
    repeat (8) @(posedge clk);
    #1;
  endtask

  task automatic wait_bit(input int i, input logic v, input int lim);
    int n;
    n = 0;
    while (status[i] !== v && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
    `CHK("status bit", v, status[i])
  endtask

  task automatic prog(input logic [7:0] op, input logic [23:0] a, input logic [7:0] d[$],
                      input int extra = 0);
    logic [7:0] q[$];
    q = {op, a[23:16], a[15:8], a[7:0]};
    q = {q, d};
    tx(q, (op == OP_QUAD_PROGRAM) ? 1 : 999, extra);
  endtask

  task automatic set_latch;
    tx({OP_WRITE_ENABLE});
    `CHK("latch", 1'b1, status.write_enable_latch)
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_wrap;
    logic [7:0] d[$];
    // the two bytes past 256 differ from the first two, so the later ones must win
    for (int i = 0; i < 258; i++) d.push_back(i[7:0] ^ {i[8], 7'h00});
    prog(OP_PAGE_PROGRAM, 24'h000100, {8'h00});
    `CHK("busy no latch", 1'b0, status.write_in_progress)
    `CHK("byte 100", 8'hFF, peek(19'h00100))
    mem[19'h00200] = 8'hF0;
    set_latch();
    prog(OP_PAGE_PROGRAM, 24'h0002FE, d);
    `CHK("busy", 1'b1, status.write_in_progress)
    wait_bit(4, 1'b0, 3000);
    `CHK("latch", 1'b0, status.write_enable_latch)
    `CHK("fail", 1'b0, status.program_fail)
    `CHK("byte 2FE", 8'h80, peek(19'h002FE))
    `CHK("byte 2FF", 8'h81, peek(19'h002FF))
    `CHK("byte 200", 8'h00, peek(19'h00200))
    `CHK("byte 201", 8'h03, peek(19'h00201))
    $display("test wrap done");
  endtask

  task automatic t_small;
    set_latch();
    prog(OP_PAGE_PROGRAM, 24'h000310, {8'hA5});
    wait_bit(4, 1'b0, 300);
    `CHK("byte 310", 8'hA5, peek(19'h00310))
    `CHK("byte 311", 8'hFF, peek(19'h00311))
    `CHK("byte 30F", 8'hFF, peek(19'h0030F))
    set_latch();
    prog(OP_PAGE_PROGRAM, 24'h000320, {8'h12}, 4);
    `CHK("busy part byte", 1'b0, status.write_in_progress)
    `CHK("byte 320", 8'hFF, peek(19'h00320))
    set_latch();
    prog(OP_QUAD_PROGRAM, 24'h000330, {8'h3C});
    `CHK("busy no quad", 1'b0, status.write_in_progress)
    @(posedge clk);
    #1 qen = 1'b1;
    set_latch();
    prog(OP_QUAD_PROGRAM, 24'h000330, {8'h3C, 8'hC3});
    wait_bit(4, 1'b0, 300);
    `CHK("quad 330", 8'h3C, peek(19'h00330))
    `CHK("quad 331", 8'hC3, peek(19'h00331))
    $display("test small done");
  endtask

  task automatic t_prot;
    @(posedge clk);
    #1 prot = 4'h7;
    set_latch();
    prog(OP_PAGE_PROGRAM, 24'h000340, {8'h00});
    `CHK("fail set", 1'b1, status.program_fail)
    `CHK("latch", 1'b0, status.write_enable_latch)
    `CHK("byte 340", 8'hFF, peek(19'h00340))
    @(posedge clk);
    #1 prot = 4'h0;
    set_latch();
    prog(OP_PAGE_PROGRAM, 24'h000341, {8'h77});
    tx({OP_RELEASE, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    `CHK("no signature busy", 16'hFFFF, host.rx)
    `CHK("busy kept", 1'b1, status.write_in_progress)
    wait_bit(4, 1'b0, 300);
    `CHK("fail clear", 1'b0, status.program_fail)
    $display("test protect done");
  endtask

  task automatic t_power;
    tx({OP_POWER_DOWN}, 999, 1);
    repeat (300) @(posedge clk);
    `CHK("down nine bits", 1'b0, status.deep_power_down)
    tx({OP_POWER_DOWN});
    `CHK("down early", 1'b0, status.deep_power_down)
    wait_bit(1, 1'b1, 300);
    tx({OP_WRITE_ENABLE});
    `CHK("latch while down", 1'b0, status.write_enable_latch)
    tx({OP_RELEASE, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    `CHK("signature", {SIG_DEFAULT, SIG_DEFAULT}, host.rx)
    `CHK("down held", 1'b1, status.deep_power_down)
    wait_bit(1, 1'b0, 300);
    tx({OP_POWER_DOWN});
    wait_bit(1, 1'b1, 300);
    tx({OP_RELEASE});
    `CHK("release early", 1'b1, status.deep_power_down)
    wait_bit(1, 1'b0, 300);
    $display("test power done");
  endtask

  task automatic t_otp;
    tx({OP_SECURE_ENTER});
    `CHK("otp mode", 1'b1, status.otp_mode)
    `CHK("reg block", 1'b1, rwb)
    set_latch();
    prog(OP_PAGE_PROGRAM, 24'h000105, {8'h42});
    wait_bit(4, 1'b0, 300);
    `CHK("otp byte", 8'h42, peek(19'h40105))
    `CHK("main byte", 8'hFF, peek(19'h00105))
    @(posedge clk);
    #1 lock = 1'b1;
    set_latch();
    prog(OP_PAGE_PROGRAM, 24'h000106, {8'h11});
    `CHK("locked fail", 1'b1, status.program_fail)
    `CHK("locked byte", 8'hFF, peek(19'h40106))
    @(posedge clk);
    #1 lock = 1'b0;
    tx({OP_SECURE_EXIT});
    `CHK("otp off", 1'b0, status.otp_mode)
    `CHK("reg free", 1'b0, rwb)
    $display("test otp done");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    rstn = 1'b0;
    qen = 1'b0;
    prot = 4'h0;
    lock = 1'b0;
    repeat (5) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (3) @(posedge clk);
    `CHK("status reset", 5'h00, status)
    t_wrap();
    t_small();
    t_prot();
    t_power();
    t_otp();
    test_done();
  end
endmodule
